//--- prcb_bank.sv
// pll ratio configuration bank: registers plus effective ratio outputs
// assumes a synchronous 8-bit register port on MCLK; auto-set from same clock domain
`timescale 1ns/100ps
`include "prcb_params.svh"
module prcb_bank
	import prcb_pkg::*;
(
	input  wire logic       MCLK,
	input  wire logic       NRST,
	input  wire logic       CLK_EN,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire prcb_byte_t REG_ADDR,
	input  wire prcb_byte_t REG_WDATA,
	input  wire logic       AUTO_SET,
	output prcb_byte_t      REG_RDATA,
	output logic [3:0]      PLL_PRE_DIV,
	output logic [4:0]      PLL_DIV_FACTOR,
	output logic [5:0]      PLL_INT_MUL,
	output logic [13:0]     PLL_FRAC,
	output logic [4:0]      PLL_FIN_MUL,
	output logic            PLL_FRAC_ZERO,
	output logic            PLL_CFG_BAD
);
	logic [3:0]  pre_div;
	logic [5:0]  int_mul;
	logic [13:0] frac;
	logic [3:0]  fin_mul;
	prcb_mode_t  mode;

	logic [3:0]  pre_ff, nxt_pre;
	logic [4:0]  divf_ff, nxt_divf;
	logic [5:0]  imul_ff, nxt_imul;
	logic [13:0] frac_ff, nxt_frac;
	logic [4:0]  fmul_ff, nxt_fmul;
	logic        fz_ff, nxt_fz;
	logic        bad_ff, nxt_bad;

	function automatic logic [4:0] plus_one(input logic [3:0] code);
		plus_one = {1'b0, code} + 5'h01;
	endfunction

	prcb_reg_file u_regs (
		.clk     (MCLK),
		.rst_n   (NRST),
		.ce      (CLK_EN),
		.wr_en   (REG_WR),
		.rd_en   (REG_RD),
		.addr    (REG_ADDR),
		.wdata   (REG_WDATA),
		.rdata   (REG_RDATA),
		.pre_div (pre_div),
		.int_mul (int_mul),
		.frac    (frac),
		.fin_mul (fin_mul)
	);

	// ----------------------------------------
	// effective ratio selection
	// ----------------------------------------
	always_comb begin
		mode = AUTO_SET ? PRCB_AUTO : PRCB_MANUAL;
		case (mode)
			PRCB_AUTO: begin
				nxt_pre  = `PRCB_AUTO_PRE_DIV;
				nxt_imul = `PRCB_AUTO_INT_MUL;
				nxt_frac = `PRCB_AUTO_FRAC;
				nxt_fmul = plus_one(`PRCB_AUTO_FIN_MUL);
				nxt_bad  = 1'b0;
			end
			PRCB_MANUAL: begin
				nxt_pre  = pre_div;
				nxt_imul = int_mul;
				nxt_frac = frac;
				nxt_fmul = plus_one(fin_mul);
				// forbidden codes flagged, not corrected
				nxt_bad  = (pre_div == 4'hF) || (int_mul == 6'h00) || (frac > `PRCB_FRAC_MAX);
			end
			default: begin
				nxt_pre  = pre_div;
				nxt_imul = int_mul;
				nxt_frac = frac;
				nxt_fmul = plus_one(fin_mul);
				nxt_bad  = 1'b0;
			end
		endcase
		nxt_divf = plus_one(nxt_pre);
		nxt_fz   = (nxt_frac == 14'h0000);
	end

	always_ff @(posedge MCLK) begin
		if (!NRST) begin
			pre_ff  <= `PRCB_RST_PRE_DIV;
			divf_ff <= 5'h01;
			imul_ff <= `PRCB_RST_INT_MUL;
			frac_ff <= 14'h0000;
			fmul_ff <= 5'h01;
			fz_ff   <= 1'b1;
			bad_ff  <= 1'b0;
		end else if (CLK_EN) begin
			pre_ff  <= nxt_pre;
			divf_ff <= nxt_divf;
			imul_ff <= nxt_imul;
			frac_ff <= nxt_frac;
			fmul_ff <= nxt_fmul;
			fz_ff   <= nxt_fz;
			bad_ff  <= nxt_bad;
		end
	end

	assign PLL_PRE_DIV    = pre_ff;
	assign PLL_DIV_FACTOR = divf_ff;
	assign PLL_INT_MUL    = imul_ff;
	assign PLL_FRAC       = frac_ff;
	assign PLL_FIN_MUL    = fmul_ff;
	assign PLL_FRAC_ZERO  = fz_ff;
	assign PLL_CFG_BAD    = bad_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_div_plus_one: assert property (@(posedge MCLK) disable iff (!NRST)
		CLK_EN && !AUTO_SET |=> PLL_PRE_DIV == $past(pre_div)
			&& PLL_DIV_FACTOR == {1'b0, $past(pre_div)} + 5'h01)
		else $error("divide factor not code plus one");
	a_auto_ignores: assert property (@(posedge MCLK) disable iff (!NRST)
		CLK_EN && AUTO_SET |=> PLL_PRE_DIV == `PRCB_AUTO_PRE_DIV && PLL_DIV_FACTOR == 5'h01
			&& PLL_INT_MUL == `PRCB_AUTO_INT_MUL && PLL_FRAC == `PRCB_AUTO_FRAC
			&& PLL_FIN_MUL == 5'h01 && !PLL_CFG_BAD)
		else $error("auto mode did not override fields");
	a_manual_follows: assert property (@(posedge MCLK) disable iff (!NRST)
		CLK_EN && !AUTO_SET |=> PLL_FRAC == $past(frac) && PLL_INT_MUL == $past(int_mul))
		else $error("manual ratio not taken from registers");
	a_fin_mul_decode: assert property (@(posedge MCLK) disable iff (!NRST)
		CLK_EN && !AUTO_SET |=> PLL_FIN_MUL == {1'b0, $past(fin_mul)} + 5'h01)
		else $error("final multiplier decode wrong");
	a_frac_zero_flag: assert property (@(posedge MCLK) disable iff (!NRST)
		PLL_FRAC_ZERO == (PLL_FRAC == 14'h0000))
		else $error("zero fraction flag mismatch");
	a_int_reset: assert property (@(posedge MCLK) !NRST |=> PLL_INT_MUL == 6'h08 && PLL_FIN_MUL == 5'h01)
		else $error("ratio outputs reset wrong");
	a_cfg_flag: assert property (@(posedge MCLK) disable iff (!NRST)
		CLK_EN && !AUTO_SET |=> PLL_CFG_BAD == ($past(pre_div) == 4'hF || $past(int_mul) == 6'h00
			|| $past(frac) > `PRCB_FRAC_MAX))
		else $error("forbidden setting flag wrong");
	a_freeze_hold: assert property (@(posedge MCLK) disable iff (!NRST)
		!CLK_EN |=> $stable(PLL_PRE_DIV) && $stable(PLL_INT_MUL) && $stable(PLL_FRAC)
			&& $stable(PLL_FIN_MUL) && $stable(PLL_CFG_BAD) && $stable(REG_RDATA))
		else $error("state moved while clock enable low");
	a_rdata_hold: assert property (@(posedge MCLK) disable iff (!NRST)
		!(CLK_EN && REG_RD) |=> $stable(REG_RDATA))
		else $error("read data changed without a read");
	a_read_int: assert property (@(posedge MCLK) disable iff (!NRST)
		CLK_EN && REG_RD && REG_ADDR == `PRCB_OFS_INT_MUL |=> REG_RDATA == {2'h0, $past(int_mul)})
		else $error("integer multiplier read back wrong");

	// ----------------------------------------
	// scenario covers
	// ----------------------------------------
	c_auto_entry: cover property (@(posedge MCLK) !AUTO_SET ##1 AUTO_SET);
	c_bad_cfg: cover property (@(posedge MCLK) PLL_CFG_BAD);
	c_max_fin: cover property (@(posedge MCLK) PLL_FIN_MUL == 5'h10);
	c_frac_limit: cover property (@(posedge MCLK) PLL_FRAC == `PRCB_FRAC_MAX && !PLL_CFG_BAD);
	c_frozen: cover property (@(posedge MCLK) NRST && !CLK_EN);
endmodule // prcb_bank

//--- prcb_params.svh
// constants of the pll ratio configuration bank
// assumes an 8-bit register port with byte addresses
// Functional notes
// - the 4-bit pre-divider code n (0 to 14) divides the reference by n plus one.
// - in clock auto-set mode all ratio fields are ignored and the block supplies its own settings.
// - the 6-bit integer multiplier is plain binary 1 to 63 and resets to 8.
// - the upper six fraction bits sit in bits 5 to 0 of one register, the whole fraction encoding 0 to 9999.
// - the lower eight fraction bits sit in a full byte register that resets to zero.
// - the ratio is integer plus four-digit decimal fraction times the final multiplier, zero fraction giving an integer ratio.
// - the 4-bit final multiplier decodes as code plus one, 1 to 16, reset code zero meaning 1.
`ifndef PRCB_PARAMS_SVH
`define PRCB_PARAMS_SVH
`define PRCB_OFS_PRE_DIV    8'h14
`define PRCB_OFS_INT_MUL    8'h15
`define PRCB_OFS_FRAC_HI    8'h16
`define PRCB_OFS_FRAC_LO    8'h17
`define PRCB_OFS_FIN_MUL    8'h18
`define PRCB_RST_PRE_DIV    4'h0
`define PRCB_RST_INT_MUL    6'h08
`define PRCB_RST_FRAC_HI    6'h00
`define PRCB_RST_FRAC_LO    8'h00
`define PRCB_RST_FIN_MUL    4'h0
`define PRCB_FRAC_MAX       14'h270F
`define PRCB_AUTO_PRE_DIV   4'h0
`define PRCB_AUTO_INT_MUL   6'h08
`define PRCB_AUTO_FRAC      14'h0000
`define PRCB_AUTO_FIN_MUL   4'h0
`endif

//--- prcb_pkg.sv
// types of the pll ratio configuration bank
// assumes prcb_params.svh is not needed for types
package prcb_pkg;
	typedef enum logic [0:0] {
		PRCB_MANUAL = 1'b0,
		PRCB_AUTO   = 1'b1
	} prcb_mode_t;
	typedef logic [7:0] prcb_byte_t;
endpackage

//--- prcb_reg_file.sv
// five-entry register memory of the ratio bank with registered read data
// assumes single-cycle write strobe and read strobe on one clock
`timescale 1ns/100ps
`include "prcb_params.svh"
module prcb_reg_file
	import prcb_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire prcb_byte_t addr,
	input  wire prcb_byte_t wdata,
	output prcb_byte_t      rdata,
	output logic [3:0]      pre_div,
	output logic [5:0]      int_mul,
	output logic [13:0]     frac,
	output logic [3:0]      fin_mul
);
	logic [3:0] pre_div_ff, nxt_pre_div;
	logic [5:0] int_mul_ff, nxt_int_mul;
	logic [5:0] frac_hi_ff, nxt_frac_hi;
	prcb_byte_t frac_lo_ff, nxt_frac_lo;
	logic [3:0] fin_mul_ff, nxt_fin_mul;
	prcb_byte_t rdata_ff, nxt_rdata;

	// ----------------------------------------
	// write decode and read mux
	// ----------------------------------------
	always_comb begin
		nxt_pre_div = pre_div_ff;
		nxt_int_mul = int_mul_ff;
		nxt_frac_hi = frac_hi_ff;
		nxt_frac_lo = frac_lo_ff;
		nxt_fin_mul = fin_mul_ff;
		nxt_rdata   = rdata_ff;
		if (wr_en) begin
			case (addr)
				`PRCB_OFS_PRE_DIV: nxt_pre_div = wdata[3:0];
				`PRCB_OFS_INT_MUL: nxt_int_mul = wdata[5:0];
				`PRCB_OFS_FRAC_HI: nxt_frac_hi = wdata[5:0];
				`PRCB_OFS_FRAC_LO: nxt_frac_lo = wdata;
				`PRCB_OFS_FIN_MUL: nxt_fin_mul = wdata[3:0];
				default: ;
			endcase
		end
		if (rd_en) begin
			case (addr)
				`PRCB_OFS_PRE_DIV: nxt_rdata = {4'h0, pre_div_ff};
				`PRCB_OFS_INT_MUL: nxt_rdata = {2'h0, int_mul_ff};
				`PRCB_OFS_FRAC_HI: nxt_rdata = {2'h0, frac_hi_ff};
				`PRCB_OFS_FRAC_LO: nxt_rdata = frac_lo_ff;
				`PRCB_OFS_FIN_MUL: nxt_rdata = {4'h0, fin_mul_ff};
				default:           nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pre_div_ff <= `PRCB_RST_PRE_DIV;
			int_mul_ff <= `PRCB_RST_INT_MUL;
			frac_hi_ff <= `PRCB_RST_FRAC_HI;
			frac_lo_ff <= `PRCB_RST_FRAC_LO;
			fin_mul_ff <= `PRCB_RST_FIN_MUL;
			rdata_ff   <= 8'h00;
		end else if (ce) begin
			pre_div_ff <= nxt_pre_div;
			int_mul_ff <= nxt_int_mul;
			frac_hi_ff <= nxt_frac_hi;
			frac_lo_ff <= nxt_frac_lo;
			fin_mul_ff <= nxt_fin_mul;
			rdata_ff   <= nxt_rdata;
		end
	end

	assign rdata   = rdata_ff;
	assign pre_div = pre_div_ff;
	assign int_mul = int_mul_ff;
	assign frac    = {frac_hi_ff, frac_lo_ff};
	assign fin_mul = fin_mul_ff;

	a_int_reset_value: assert property (@(posedge clk) !rst_n |=> int_mul_ff == 6'h08)
		else $error("integer multiplier reset value wrong");
	a_frac_lo_write: assert property (@(posedge clk) disable iff (!rst_n)
		ce && wr_en && addr == `PRCB_OFS_FRAC_LO |=> frac_lo_ff == $past(wdata))
		else $error("fraction low byte not written");
endmodule // prcb_reg_file

//--- prcb_bank_test.sv
// testbench of the pll ratio configuration bank
// assumes prcb_bank with registered read data and registered ratio outputs
`timescale 1ns/100ps
`include "prcb_params.svh"
module prcb_bank_test
	import prcb_pkg::*;
;
	logic       mclk, nrst, clk_en, reg_wr, reg_rd, auto_set;
	prcb_byte_t reg_addr, reg_wdata, reg_rdata;
	logic [3:0] pre_div;
	logic [4:0] div_factor, fin_mul;
	logic [5:0] int_mul;
	logic [13:0] frac;
	logic       frac_zero, cfg_bad;
	int         bad_count, check_count;
	prcb_bank u_prcb_bank (.MCLK(mclk), .NRST(nrst), .CLK_EN(clk_en), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .AUTO_SET(auto_set), .REG_RDATA(reg_rdata),
		.PLL_PRE_DIV(pre_div), .PLL_DIV_FACTOR(div_factor), .PLL_INT_MUL(int_mul), .PLL_FRAC(frac),
		.PLL_FIN_MUL(fin_mul), .PLL_FRAC_ZERO(frac_zero), .PLL_CFG_BAD(cfg_bad));
	// ----------------------------------------
	// checking helpers
	// ----------------------------------------
	task automatic report(input logic [35:0] got, input logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [35:0] mk(input logic [3:0] p, input logic [5:0] j, input logic [13:0] d,
		input logic [3:0] r);
		mk = {p, 5'(p) + 5'h01, j, d, 5'(r) + 5'h01, d == 14'h0000, p == 4'hF || j == 6'h00 || d > 14'h270F};
	endfunction
	task automatic chk_out(input logic [35:0] e);
		report({pre_div, div_factor, int_mul, frac, fin_mul, frac_zero, cfg_bad}, e);
	endtask
	task automatic wr(input prcb_byte_t a, input prcb_byte_t d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		@(negedge mclk);
	endtask
	task automatic rd(input prcb_byte_t a, input prcb_byte_t e);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		report(36'(reg_rdata), 36'(e));
		@(negedge mclk);
	endtask
	task automatic close_out;
		if (bad_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd(`PRCB_OFS_PRE_DIV, 8'h00);
		rd(`PRCB_OFS_INT_MUL, 8'h08);
		rd(`PRCB_OFS_FRAC_HI, 8'h00);
		rd(`PRCB_OFS_FRAC_LO, 8'h00);
		rd(`PRCB_OFS_FIN_MUL, 8'h00);
		chk_out(mk(4'h0, 6'h08, 14'h0000, 4'h0));
	endtask
	task automatic t_pre;
		wr(`PRCB_OFS_PRE_DIV, 8'h0E);
		chk_out(mk(4'hE, 6'h08, 14'h0000, 4'h0));
		wr(`PRCB_OFS_PRE_DIV, 8'hFF);
		rd(`PRCB_OFS_PRE_DIV, 8'h0F);
		chk_out(mk(4'hF, 6'h08, 14'h0000, 4'h0));
		wr(`PRCB_OFS_PRE_DIV, 8'h00);
	endtask
	task automatic t_int;
		wr(`PRCB_OFS_INT_MUL, 8'hC1);
		rd(`PRCB_OFS_INT_MUL, 8'h01);
		wr(`PRCB_OFS_INT_MUL, 8'h3F);
		chk_out(mk(4'h0, 6'h3F, 14'h0000, 4'h0));
		wr(`PRCB_OFS_INT_MUL, 8'h00);
		chk_out(mk(4'h0, 6'h00, 14'h0000, 4'h0));
		wr(`PRCB_OFS_INT_MUL, 8'h08);
	endtask
	task automatic t_frac;
		wr(`PRCB_OFS_FRAC_HI, 8'hE7);
		wr(`PRCB_OFS_FRAC_LO, 8'h0F);
		rd(`PRCB_OFS_FRAC_HI, 8'h27);
		chk_out(mk(4'h0, 6'h08, 14'h270F, 4'h0));
		wr(`PRCB_OFS_FRAC_LO, 8'h10);
		chk_out(mk(4'h0, 6'h08, 14'h2710, 4'h0));
		wr(`PRCB_OFS_FRAC_HI, 8'h00);
		rd(`PRCB_OFS_FRAC_LO, 8'h10);
		wr(`PRCB_OFS_FRAC_LO, 8'h00);
		chk_out(mk(4'h0, 6'h08, 14'h0000, 4'h0));
	endtask
	task automatic t_fin;
		for (int i = 0; i < 16; i++) begin
			wr(`PRCB_OFS_FIN_MUL, 8'hF0 | 8'(i));
			rd(`PRCB_OFS_FIN_MUL, 8'(i));
			chk_out(mk(4'h0, 6'h08, 14'h0000, 4'(i)));
		end
	endtask
	task automatic t_auto;
		wr(`PRCB_OFS_PRE_DIV, 8'h0F);
		wr(`PRCB_OFS_INT_MUL, 8'h00);
		wr(`PRCB_OFS_FRAC_LO, 8'h55);
		wr(`PRCB_OFS_FIN_MUL, 8'h07);
		auto_set = 1'b1;
		@(negedge mclk);
		chk_out(mk(`PRCB_AUTO_PRE_DIV, `PRCB_AUTO_INT_MUL, `PRCB_AUTO_FRAC, `PRCB_AUTO_FIN_MUL));
		rd(`PRCB_OFS_PRE_DIV, 8'h0F);
		auto_set = 1'b0;
		@(negedge mclk);
		chk_out(mk(4'hF, 6'h00, 14'h0055, 4'h7));
	endtask
	task automatic t_misc;
		wr(8'h19, 8'hAA);
		rd(8'h19, 8'h00);
		rd(8'h13, 8'h00);
		clk_en = 1'b0;
		wr(`PRCB_OFS_INT_MUL, 8'h3F);
		clk_en = 1'b1;
		rd(`PRCB_OFS_INT_MUL, 8'h00);
	endtask
	// ----------------------------------------
	// clock and main sequence
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		{nrst, reg_wr, reg_rd, auto_set} = 4'h0;
		clk_en = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		bad_count = 0;
		check_count = 0;
		repeat (8) @(negedge mclk);
		nrst = 1'b1;
		t_reset();
		t_pre();
		t_int();
		t_frac();
		t_fin();
		t_auto();
		t_misc();
		nrst = 1'b0;
		repeat (2) @(negedge mclk);
		nrst = 1'b1;
		t_reset();
		close_out();
	end
endmodule // prcb_bank_test
